// ==== bfpm_host.sv ====
// serial host model; released line reads high through the pull-up
`timescale 1ns/1ps
module bfpm_host (
    // clock and device drive
    input wire logic i_clock,
    input wire logic i_sda_oe,
    // bus lines
    output logic o_scl,
    output logic o_sda
);
    logic pl = 1'b0;
    initial o_scl = 1'b1;
    assign o_sda = !(pl || i_sda_oe);
    // slow phases so the three-flop sync never sees data move with scl high
    task automatic hw();
        repeat (10) @(negedge i_clock);
    endtask : hw
    task automatic st();
        pl = 1'b0;
        hw();
        o_scl = 1'b1;
        hw();
        pl = 1'b1;
        hw();
        o_scl = 1'b0;
    endtask : st
    task automatic sp();
        hw();
        pl = 1'b1;
        hw();
        o_scl = 1'b1;
        hw();
        pl = 1'b0;
        hw();
    endtask : sp
    task automatic bt(input logic v, output logic r);
        hw();
        pl = v;
        hw();
        o_scl = 1'b1;
        hw();
        r = o_sda;
        o_scl = 1'b0;
    endtask : bt
    // msb first; m pulls the ninth slot low
    task automatic xb(input logic [7:0] d, input logic m, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bt(!d[i], q[i]);
        end
        bt(m, a);
    endtask : xb
endmodule : bfpm_host

// ==== bfpm_i2c.sv ====
// serial register port slave: pointer write, data write, auto-increment read
`timescale 1ns/1ps
module bfpm_i2c #(
    parameter logic [6:0] DEV_ADDR = 7'h2A
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // synchronised bus lines
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    // register side
    output logic [7:0] o_addr,
    input wire logic [7:0] i_rdata,
    output logic o_wr_stb,
    output logic [7:0] o_wr_data
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK}
        bfpm_i2c_e;
    typedef struct packed {
        bfpm_i2c_e st;
        bfpm_i2c_e after;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic drive;
        logic nack;
        logic scl_d;
        logic sda_d;
        logic wr;
        logic [7:0] wdata;
    } bfpm_i2c_s;

    bfpm_i2c_s state_ff;
    bfpm_i2c_s nxt_state;
    logic rise;
    logic fall;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.scl_d = i_scl;
        nxt_state.sda_d = i_sda;
        nxt_state.wr = 1'b0;
        rise = i_scl & ~state_ff.scl_d;
        fall = ~i_scl & state_ff.scl_d;
        if (i_scl && state_ff.sda_d && !i_sda) begin
            nxt_state.st = ST_ADDR;
            nxt_state.cnt = 4'h0;
            nxt_state.drive = 1'b0;
        end else if (i_scl && !state_ff.sda_d && i_sda) begin
            nxt_state.st = ST_IDLE;
            nxt_state.drive = 1'b0;
        end else begin
            unique case (state_ff.st)
                ST_IDLE: begin
                    nxt_state.drive = 1'b0;
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (rise) begin
                        nxt_state.sh = {state_ff.sh[6:0], i_sda};
                        nxt_state.cnt = state_ff.cnt + 4'h1;
                    end else if (fall && state_ff.cnt == 4'h8) begin
                        nxt_state.cnt = 4'h0;
                        nxt_state.drive = 1'b1;
                        nxt_state.st = ST_ACK;
                        nxt_state.after = ST_WDATA;
                        if (state_ff.st == ST_ADDR) begin
                            nxt_state.after = state_ff.sh[0] ? ST_RDATA : ST_PTR;
                            if (state_ff.sh[7:1] != DEV_ADDR) begin
                                nxt_state.drive = 1'b0;
                                nxt_state.st = ST_IDLE;
                            end
                        end else if (state_ff.st == ST_PTR) begin
                            nxt_state.ptr = state_ff.sh;
                        end else begin
                            nxt_state.wr = 1'b1;
                            nxt_state.wdata = state_ff.sh;
                            nxt_state.ptr = state_ff.ptr + 8'h01;
                        end
                    end
                end
                ST_ACK, ST_RACK: begin
                    if (rise) begin
                        nxt_state.nack = i_sda;
                    end else if (fall) begin
                        nxt_state.st = state_ff.after;
                        nxt_state.drive = 1'b0;
                        if (state_ff.after == ST_RDATA) begin
                            // a released line on the master's ack ends the read
                            if (state_ff.st == ST_RACK && state_ff.nack) begin
                                nxt_state.st = ST_IDLE;
                            end else begin
                                nxt_state.sh = {i_rdata[6:0], 1'b0};
                                nxt_state.drive = ~i_rdata[7];
                                nxt_state.cnt = 4'h1;
                            end
                        end
                    end
                end
                ST_RDATA: begin
                    if (fall) begin
                        if (state_ff.cnt == 4'h8) begin
                            nxt_state.drive = 1'b0;
                            nxt_state.st = ST_RACK;
                            nxt_state.after = ST_RDATA;
                            nxt_state.ptr = state_ff.ptr + 8'h01;
                        end else begin
                            nxt_state.drive = ~state_ff.sh[7];
                            nxt_state.sh = {state_ff.sh[6:0], 1'b0};
                            nxt_state.cnt = state_ff.cnt + 4'h1;
                        end
                    end
                end
            endcase
        end
        if (!i_rst_b) begin
            nxt_state = '0;
            nxt_state.scl_d = 1'b1;
            nxt_state.sda_d = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        state_ff <= nxt_state;
    end

    assign o_sda_o = 1'b0;
    assign o_sda_oe = state_ff.drive;
    assign o_addr = state_ff.wr ? state_ff.ptr - 8'h01 : state_ff.ptr;
    assign o_wr_stb = state_ff.wr;
    assign o_wr_data = state_ff.wdata;
endmodule : bfpm_i2c

// ==== bfpm_pkg.sv ====
// package: register map, field positions, reset values and timing for the fault manager
// What this block does
// - sample limit pin voltage at power on
// - internal 5-bit per-phase limit threshold field
// - select bit picks pin or internal threshold
// - stage temperature fault latches or hiccups
// - masked stage temperature fault takes no action
// - per-phase current limiting active by default
// - output undervoltage latches the device off
// - latched off until enable is toggled
// - floor reached suspends phase limiting 2 ms
// - floor threshold programmable over serial bus
// - total overcurrent latches, phases go mid
// - nothing active until supply above lockout
// - overvoltage drops power ok, driver, phases
// - fixed overvoltage limit when guard disabled
// - line input undervoltage latches device off
// - temperature mask bit 5 blocks action
// - total limit mask bit 3 blocks action
package bfpm_pkg;
    // register offsets
    localparam logic [7:0] ADDR_FAULT_MASK = 8'h22;
    localparam logic [7:0] ADDR_FAULT_STATUS = 8'h23;
    localparam logic [7:0] ADDR_SAMPLED_LIMIT = 8'h2D;
    localparam logic [7:0] ADDR_INTERNAL_LIMIT = 8'h2E;
    localparam logic [7:0] ADDR_LATCH_A = 8'h46;
    localparam logic [7:0] ADDR_LATCH_B = 8'h47;
    localparam logic [7:0] ADDR_TEMP_RESP = 8'h4A;
    localparam logic [7:0] ADDR_FLOOR_CFG = 8'h4E;
    localparam logic [7:0] ADDR_OVP_CFG = 8'h4F;
    localparam logic [7:0] ADDR_UVP_CFG = 8'h50;
    // field positions (mask and status share positions)
    localparam int BIT_OV = 0;
    localparam int BIT_UV = 1;
    localparam int BIT_PHASE_LIMIT_OFF = 2;
    localparam int BIT_TOTAL_LIMIT = 3;
    localparam int BIT_STAGE_TEMP = 5;
    localparam int BIT_LINE_UV = 6;
    localparam int BIT_LIMIT_SEL = 0;
    localparam int BIT_TEMP_HICCUP = 7;
    localparam int BIT_FLOOR_EN = 7;
    localparam int BIT_GUARD_OFF = 0;
    localparam int LIMIT_CODE_W = 5;
    localparam int FLOOR_CODE_W = 5;
    localparam int TEMP_CODE_W = 7;
    // reset values
    localparam logic [7:0] RST_FAULT_MASK = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    // timing
    localparam int CLK_MHZ = 200;
    localparam int SUSPEND_US = 2000;
    localparam int HICCUP_US = 10000;
    localparam int SAMPLE_US = 50;
    // synchronised input positions; phase flags follow IN_PHASE0
    localparam int IN_SUPPLY_OK = 0;
    localparam int IN_ENABLE = 1;
    localparam int IN_OUT_UNDER = 2;
    localparam int IN_OUT_OVER_REL = 3;
    localparam int IN_OUT_OVER_ABS = 4;
    localparam int IN_LINE_UNDER = 5;
    localparam int IN_TOTAL_LIMIT = 6;
    localparam int IN_STAGE_TEMP = 7;
    localparam int IN_FLOOR = 8;
    localparam int IN_SCL = 9;
    localparam int IN_SDA = 10;
    localparam int IN_PHASE0 = 11;
    // phase output drive
    typedef enum logic [1:0] {PWM_LOW, PWM_MID, PWM_RUN} bfpm_pwm_e;
endpackage : bfpm_pkg

// ==== bfpm_properties.sv ====
// concurrent checks on the fault manager top ports
`timescale 1ns/1ps
module bfpm_properties (
    // watched ports
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_supply_ok,
    input wire logic i_enable,
    input wire logic i_out_over_rel,
    input wire logic i_total_limit_fault,
    input wire logic o_limit_source_on,
    input bfpm_pkg::bfpm_pwm_e o_pwm_ctl,
    input wire logic o_driver_on_output,
    input wire logic o_power_ok_output,
    input wire logic o_fault_latched
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    a_run_outputs: assert property (o_driver_on_output |-> o_power_ok_output
        && o_pwm_ctl == bfpm_pkg::PWM_RUN) else $error("run outputs wrong");
    a_reset_quiet: assert property (!$past(i_rst_b) |-> !o_driver_on_output
        && o_pwm_ctl == bfpm_pkg::PWM_LOW) else $error("busy after reset");
    a_source_idle: assert property (o_limit_source_on |-> !o_driver_on_output)
        else $error("source on while running");
    a_latch_blocks: assert property (o_fault_latched |-> !o_driver_on_output
        && !o_power_ok_output) else $error("latched but running");
    // mid only from total limit; sync plus one edge
    a_mid_cause: assert property ($rose(o_pwm_ctl == bfpm_pkg::PWM_MID)
        |-> $past(i_total_limit_fault, 5)) else $error("mid without cause");
    a_over_drops: assert property ($rose(i_out_over_rel) && o_driver_on_output
        |-> ##[1:8] !o_power_ok_output) else $error("overvoltage ignored");
    a_supply_gate: assert property (!i_supply_ok [*6] |-> !o_driver_on_output)
        else $error("running below lockout");
    a_enable_clears: assert property (!i_enable [*6] |-> !o_fault_latched
        && !o_driver_on_output) else $error("enable low not cleared");
    c_mid: cover property (o_pwm_ctl == bfpm_pkg::PWM_MID);
    c_latch: cover property ($rose(o_fault_latched));
    c_sampled: cover property ($fell(o_limit_source_on));
endmodule : bfpm_properties
bind bfpm_top bfpm_properties u_props (.*);

// ==== bfpm_sync.sv ====
// three-flop synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
module bfpm_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // pins
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_stable
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } bfpm_sync_s;

    bfpm_sync_s state_ff;
    bfpm_sync_s nxt_state;

    always_comb begin
        nxt_state.s1 = i_async;
        nxt_state.s2 = state_ff.s1;
        nxt_state.s3 = state_ff.s2;
        // only the second and third stages are compared
        for (int i = 0; i < W; i++) begin
            nxt_state.val[i] = (state_ff.s2[i] == state_ff.s3[i]) ? state_ff.s3[i]
                                                                  : state_ff.val[i];
        end
        if (!i_rst_b) begin
            nxt_state = '0;
        end
    end

    always_ff @(posedge i_clock) begin
        state_ff <= nxt_state;
    end

    assign o_stable = state_ff.val;
endmodule : bfpm_sync

// ==== bfpm_top.sv ====
// fault protection and current limit selection logic of the buck controller
`timescale 1ns/1ps
module bfpm_top #(
    parameter int N_PHASE = 8,
    parameter int SUSPEND_CYC = bfpm_pkg::SUSPEND_US * bfpm_pkg::CLK_MHZ,
    parameter int HICCUP_CYC = bfpm_pkg::HICCUP_US * bfpm_pkg::CLK_MHZ,
    parameter int SAMPLE_CYC = bfpm_pkg::SAMPLE_US * bfpm_pkg::CLK_MHZ,
    parameter logic [6:0] DEV_ADDR = 7'h2A
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // serial register port
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    // analog comparator flags and pins
    input wire logic i_supply_ok,
    input wire logic i_enable,
    input wire logic i_out_under,
    input wire logic i_out_over_rel,
    input wire logic i_out_over_abs,
    input wire logic i_line_under,
    input wire logic i_total_limit_fault,
    input wire logic i_stage_temp_signal,
    input wire logic i_floor_reached,
    input wire logic [N_PHASE-1:0] i_phase_over,
    // converter result of the limit pin voltage
    input wire logic [7:0] i_limit_adc,
    // threshold selection to the analog side
    output logic o_limit_source_on,
    output logic o_limit_sel_internal,
    output logic [bfpm_pkg::LIMIT_CODE_W-1:0] o_internal_limit_code,
    output logic [bfpm_pkg::TEMP_CODE_W-1:0] o_stage_temp_thresh,
    output logic [bfpm_pkg::FLOOR_CODE_W-1:0] o_limit_suspend_floor,
    // power stage control
    output logic [N_PHASE-1:0] o_per_phase_current_limiting,
    output bfpm_pkg::bfpm_pwm_e o_pwm_ctl,
    output logic o_driver_on_output,
    output logic o_power_ok_output,
    output logic o_fault_latched
);
    localparam int IN_W = bfpm_pkg::IN_PHASE0 + N_PHASE;

    typedef enum logic [2:0] {ST_OFF, ST_SAMPLE, ST_IDLE, ST_RUN, ST_HICCUP, ST_LATCH,
        ST_LATCH_MID} bfpm_main_e;
    typedef struct packed {
        bfpm_main_e st;
        logic [23:0] tmr;
        logic [23:0] sus_tmr;
        logic [7:0] mask;
        logic [7:0] status;
        logic [7:0] sampled;
        logic [7:0] int_lim;
        logic [7:0] latch_a;
        logic [7:0] latch_b;
        logic [7:0] temp_resp;
        logic [7:0] floor_cfg;
        logic [7:0] ovp_cfg;
        logic [7:0] uvp_cfg;
        logic [N_PHASE-1:0] ph_lim;
        bfpm_pkg::bfpm_pwm_e pwm;
        logic pok;
        logic driver_on_output;
        logic src_on;
    } bfpm_main_s;

    bfpm_main_s state_ff;
    bfpm_main_s nxt_state;
    logic [IN_W-1:0] pins;
    logic [IN_W-1:0] s;
    logic [7:0] reg_addr;
    logic [7:0] rdata;
    logic wr_stb;
    logic [7:0] wr_data;
    logic run;
    logic en;
    logic f_uv;
    logic f_ov;
    logic f_line;
    logic f_tot;
    logic f_tmp;
    logic [7:0] set_bits;
    logic latch_low;
    logic latch_mid;
    logic hiccup_go;
    logic limit_on;
    logic [N_PHASE-1:0] ph_over;

    assign pins = {i_phase_over, i_sda, i_scl, i_floor_reached, i_stage_temp_signal,
                   i_total_limit_fault, i_line_under, i_out_over_abs, i_out_over_rel,
                   i_out_under, i_enable, i_supply_ok};

    bfpm_sync #(
        .W(IN_W)
    ) u_sync (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_async(pins),
        .o_stable(s)
    );

    bfpm_i2c #(
        .DEV_ADDR(DEV_ADDR)
    ) u_i2c (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_scl(s[bfpm_pkg::IN_SCL]),
        .i_sda(s[bfpm_pkg::IN_SDA]),
        .o_sda_o(o_sda_o),
        .o_sda_oe(o_sda_oe),
        .o_addr(reg_addr),
        .i_rdata(rdata),
        .o_wr_stb(wr_stb),
        .o_wr_data(wr_data)
    );

    // unmapped offsets read as zero
    always_comb begin
        unique case (reg_addr)
            bfpm_pkg::ADDR_FAULT_MASK: rdata = state_ff.mask;
            bfpm_pkg::ADDR_FAULT_STATUS: rdata = state_ff.status;
            bfpm_pkg::ADDR_SAMPLED_LIMIT: rdata = state_ff.sampled;
            bfpm_pkg::ADDR_INTERNAL_LIMIT: rdata = state_ff.int_lim;
            bfpm_pkg::ADDR_LATCH_A: rdata = state_ff.latch_a;
            bfpm_pkg::ADDR_LATCH_B: rdata = state_ff.latch_b;
            bfpm_pkg::ADDR_TEMP_RESP: rdata = state_ff.temp_resp;
            bfpm_pkg::ADDR_FLOOR_CFG: rdata = state_ff.floor_cfg;
            bfpm_pkg::ADDR_OVP_CFG: rdata = state_ff.ovp_cfg;
            bfpm_pkg::ADDR_UVP_CFG: rdata = state_ff.uvp_cfg;
            default: rdata = 8'h00;
        endcase
    end

    always_comb begin
        nxt_state = state_ff;
        run = (state_ff.st == ST_RUN);
        en = s[bfpm_pkg::IN_ENABLE];
        ph_over = s[IN_W-1:bfpm_pkg::IN_PHASE0];
        f_uv = run & s[bfpm_pkg::IN_OUT_UNDER] & ~state_ff.uvp_cfg[bfpm_pkg::BIT_GUARD_OFF];
        f_ov = run & (state_ff.ovp_cfg[bfpm_pkg::BIT_GUARD_OFF] ? s[bfpm_pkg::IN_OUT_OVER_ABS]
                                                                : s[bfpm_pkg::IN_OUT_OVER_REL]);
        f_line = run & s[bfpm_pkg::IN_LINE_UNDER];
        f_tot = run & s[bfpm_pkg::IN_TOTAL_LIMIT];
        f_tmp = run & s[bfpm_pkg::IN_STAGE_TEMP];
        set_bits = 8'h00;
        set_bits[bfpm_pkg::BIT_OV] = f_ov;
        set_bits[bfpm_pkg::BIT_UV] = f_uv;
        set_bits[bfpm_pkg::BIT_LINE_UV] = f_line;
        set_bits[bfpm_pkg::BIT_TOTAL_LIMIT] = f_tot;
        set_bits[bfpm_pkg::BIT_STAGE_TEMP] = f_tmp;
        latch_mid = f_tot & ~state_ff.mask[bfpm_pkg::BIT_TOTAL_LIMIT];
        hiccup_go = f_tmp & ~state_ff.mask[bfpm_pkg::BIT_STAGE_TEMP]
                  & state_ff.temp_resp[bfpm_pkg::BIT_TEMP_HICCUP];
        latch_low = f_uv | f_ov | (f_line & ~state_ff.mask[bfpm_pkg::BIT_LINE_UV])
                  | (f_tmp & ~state_ff.mask[bfpm_pkg::BIT_STAGE_TEMP]
                     & ~state_ff.temp_resp[bfpm_pkg::BIT_TEMP_HICCUP]);

        // clear on enable low, set wins
        nxt_state.status = set_bits | (state_ff.status & {8{en}});

        if (wr_stb) begin
            unique case (reg_addr)
                bfpm_pkg::ADDR_FAULT_MASK: nxt_state.mask = wr_data;
                bfpm_pkg::ADDR_INTERNAL_LIMIT: nxt_state.int_lim = wr_data;
                bfpm_pkg::ADDR_LATCH_A: nxt_state.latch_a = wr_data;
                bfpm_pkg::ADDR_LATCH_B: nxt_state.latch_b = wr_data;
                bfpm_pkg::ADDR_TEMP_RESP: nxt_state.temp_resp = wr_data;
                bfpm_pkg::ADDR_FLOOR_CFG: nxt_state.floor_cfg = wr_data;
                bfpm_pkg::ADDR_OVP_CFG: nxt_state.ovp_cfg = wr_data;
                bfpm_pkg::ADDR_UVP_CFG: nxt_state.uvp_cfg = wr_data;
                default: nxt_state.mask = state_ff.mask;
            endcase
        end

        // limiting on unless mask disables it or the floor suspension timer is running
        limit_on = ~state_ff.mask[bfpm_pkg::BIT_PHASE_LIMIT_OFF] && (state_ff.sus_tmr == 24'h0);
        if (state_ff.sus_tmr != 24'h0) begin
            nxt_state.sus_tmr = state_ff.sus_tmr - 24'h000001;
        end else if (run && limit_on && (|ph_over) && s[bfpm_pkg::IN_FLOOR]
                     && state_ff.floor_cfg[bfpm_pkg::BIT_FLOOR_EN]) begin
            nxt_state.sus_tmr = 24'(SUSPEND_CYC);
        end
        if (!run) begin
            nxt_state.sus_tmr = 24'h0;
        end

        if (!s[bfpm_pkg::IN_SUPPLY_OK]) begin
            nxt_state.st = ST_OFF;
            nxt_state.src_on = 1'b0;
        end else begin
            unique case (state_ff.st)
                ST_OFF: begin
                    nxt_state.st = ST_SAMPLE;
                    nxt_state.tmr = 24'(SAMPLE_CYC);
                    nxt_state.src_on = 1'b1;
                end
                ST_SAMPLE: begin
                    if (state_ff.tmr <= 24'h000001) begin
                        nxt_state.sampled = i_limit_adc;
                        nxt_state.src_on = 1'b0;
                        nxt_state.st = ST_IDLE;
                    end else begin
                        nxt_state.tmr = state_ff.tmr - 24'h000001;
                    end
                end
                ST_IDLE: begin
                    if (en) begin
                        nxt_state.st = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!en) begin
                        nxt_state.st = ST_IDLE;
                    end else if (f_ov) begin
                        nxt_state.st = ST_LATCH;
                    end else if (latch_mid) begin
                        nxt_state.st = ST_LATCH_MID;
                    end else if (latch_low) begin
                        nxt_state.st = ST_LATCH;
                    end else if (hiccup_go) begin
                        nxt_state.st = ST_HICCUP;
                        nxt_state.tmr = 24'(HICCUP_CYC);
                    end
                end
                ST_HICCUP: begin
                    if (!en) begin
                        nxt_state.st = ST_IDLE;
                    end else if (state_ff.tmr <= 24'h000001) begin
                        nxt_state.st = ST_RUN;
                    end else begin
                        nxt_state.tmr = state_ff.tmr - 24'h000001;
                    end
                end
                ST_LATCH, ST_LATCH_MID: begin
                    if (!en) begin
                        nxt_state.st = ST_IDLE;
                    end
                end
            endcase
        end

        // outputs follow the next state so a fault acts on the next edge
        nxt_state.driver_on_output = (nxt_state.st == ST_RUN);
        nxt_state.pok = (nxt_state.st == ST_RUN);
        nxt_state.pwm = (nxt_state.st == ST_RUN) ? bfpm_pkg::PWM_RUN
                      : (nxt_state.st == ST_LATCH_MID) ? bfpm_pkg::PWM_MID : bfpm_pkg::PWM_LOW;
        nxt_state.ph_lim = ((nxt_state.st == ST_RUN) && limit_on) ? ph_over : '0;

        if (!i_rst_b) begin
            nxt_state = '0;
            nxt_state.st = ST_OFF;
            nxt_state.mask = bfpm_pkg::RST_FAULT_MASK;
            nxt_state.status = bfpm_pkg::RST_STATUS;
            nxt_state.int_lim = bfpm_pkg::RST_CONFIG;
            nxt_state.latch_a = bfpm_pkg::RST_CONFIG;
            nxt_state.latch_b = bfpm_pkg::RST_CONFIG;
            nxt_state.temp_resp = bfpm_pkg::RST_CONFIG;
            nxt_state.floor_cfg = bfpm_pkg::RST_CONFIG;
            nxt_state.ovp_cfg = bfpm_pkg::RST_CONFIG;
            nxt_state.uvp_cfg = bfpm_pkg::RST_CONFIG;
            nxt_state.pwm = bfpm_pkg::PWM_LOW;
        end
    end

    always_ff @(posedge i_clock) begin
        state_ff <= nxt_state;
    end

    assign o_limit_source_on = state_ff.src_on;
    assign o_limit_sel_internal = state_ff.latch_a[bfpm_pkg::BIT_LIMIT_SEL];
    assign o_internal_limit_code = state_ff.int_lim[bfpm_pkg::LIMIT_CODE_W-1:0];
    assign o_stage_temp_thresh = state_ff.temp_resp[bfpm_pkg::TEMP_CODE_W-1:0];
    assign o_limit_suspend_floor = state_ff.floor_cfg[bfpm_pkg::FLOOR_CODE_W-1:0];
    assign o_per_phase_current_limiting = state_ff.ph_lim;
    assign o_pwm_ctl = state_ff.pwm;
    assign o_driver_on_output = state_ff.driver_on_output;
    assign o_power_ok_output = state_ff.pok;
    assign o_fault_latched = (state_ff.st == ST_LATCH) || (state_ff.st == ST_LATCH_MID);
endmodule : bfpm_top

// ==== tb.sv ====
// testbench: register port, power-on sample, fault responses
`timescale 1ns/1ps
module tb;
    logic clk = 0, rst_b = 0, sup = 0, en = 0, flr = 0, sda_oe, scl, sda, lsel, src;
    logic [5:0] flt = '0;
    logic [7:0] ph = '0, q, per, adc = 8'h5A;
    logic [6:0] tt;
    logic [4:0] lc, fc;
    logic driver_on_output, pok, lat;
    bfpm_pkg::bfpm_pwm_e pwm;
    int error_cnt = 0, checks = 0;
    initial forever #2.5 clk = ~clk;
    bfpm_host h (.i_clock(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
    bfpm_top #(.SUSPEND_CYC(20), .HICCUP_CYC(30), .SAMPLE_CYC(5)) dut (
        .i_clock(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda), .o_sda_o(),
        .o_sda_oe(sda_oe), .i_supply_ok(sup), .i_enable(en), .i_out_under(flt[0]),
        .i_out_over_rel(flt[1]), .i_line_under(flt[2]), .i_total_limit_fault(flt[3]),
        .i_stage_temp_signal(flt[4]), .i_out_over_abs(flt[5]), .i_floor_reached(flr),
        .i_phase_over(ph), .i_limit_adc(adc), .o_limit_source_on(src),
        .o_limit_sel_internal(lsel), .o_internal_limit_code(lc), .o_stage_temp_thresh(tt),
        .o_limit_suspend_floor(fc), .o_per_phase_current_limiting(per), .o_pwm_ctl(pwm),
        .o_driver_on_output(driver_on_output), .o_power_ok_output(pok), .o_fault_latched(lat));
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        h.st();
        h.xb(8'h54, 1'b0, q);
        h.xb(a, 1'b0, q);
        h.xb(d, 1'b0, q);
        h.sp();
    endtask : wr
    // pointer write, repeated start, one byte then nack
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        h.st();
        h.xb(8'h54, 1'b0, q);
        h.xb(a, 1'b0, q);
        h.st();
        h.xb(8'h55, 1'b0, q);
        h.xb(8'hFF, 1'b0, q);
        h.sp();
        cmp(n, e, q);
    endtask : rd
    task automatic report_and_stop();
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    initial begin
        wt(8);
        rst_b = 1;
        wt(10);
        cmp("driver_on_output", 0, driver_on_output);
        sup = 1;
        wt(30);
        rd(8'h2D, 8'h5A, "limit");
        rd(8'h22, 8'h00, "mask");
        adc = 8'h33;
        wr(8'h2D, 8'h00);
        rd(8'h2D, 8'h5A, "ro");
        rd(8'h60, 8'h00, "unmap");
        wr(8'h2E, 8'h1F);
        cmp("lcode", 8'h1F, {3'h0, lc});
        wr(8'h46, 8'h01);
        cmp("lsel", 1, lsel);
        wr(8'h4E, 8'h85);
        cmp("floor", 8'h05, {3'h0, fc});
        en = 1;
        ph = 8'h01;
        wt(10);
        cmp("limit", 8'h01, per);
        flr = 1;
        wt(10);
        cmp("suspend", 0, per);
        flr = 0;
        wt(20);
        cmp("restore", 8'h01, per);
        // one latch pass per fault pin; total limit goes mid
        for (int i = 0; i < 6; i++) begin
            if (i == 5)
                wr(8'h4F, 8'h01);
            flt[i] = 1;
            wt(8);
            cmp("driver_on_output pok", 8'h00, {6'h0, driver_on_output, pok});
            cmp("pwm", (i == 3) ? 8'h01 : 8'h00, {6'h0, pwm});
            flt[i] = 0;
            wt(8);
            cmp("held", 1, lat);
            en = 0;
            wt(8);
            cmp("clear", 0, lat);
            en = 1;
            wt(8);
            cmp("rerun", 8'h03, {6'h0, driver_on_output, pok});
        end
        wr(8'h22, 8'h28);
        flt[4:3] = 2'b11;
        wt(8);
        cmp("masked", 1, driver_on_output);
        rd(8'h23, 8'h28, "status");
        flt[4:3] = 2'b00;
        wr(8'h22, 8'h00);
        wr(8'h4A, 8'hC5);
        cmp("tthr", 8'h45, {1'b0, tt});
        flt[4] = 1;
        wt(8);
        cmp("hiccup", 0, driver_on_output);
        flt[4] = 0;
        wt(40);
        cmp("retry", 1, driver_on_output);
        sup = 0;
        wt(8);
        cmp("lockout", 0, driver_on_output);
        sup = 1;
        wt(7);
        cmp("src on", 1, src);
        wt(8);
        cmp("src off", 0, src);
        rd(8'h2D, 8'h33, "resample");
        report_and_stop();
    end
    initial begin
        wt(60000);
        error_cnt++;
        report_and_stop();
    end
endmodule : tb
